// [rtl/dspi_top.sv]
// Port interface of a separate-I/O double-data-rate two-word burst SRAM
`timescale 1ns/1ps
`include "dspi_cfg.svh"
module dspi_top
    import dspi_pkg::*;
#(
    parameter int DATA_W = `DSPI_DATA_W,
    parameter int ADDR_W = `DSPI_ADDR_W,
    parameter int FIFO_DEPTH = `DSPI_FIFO_DEPTH,
    parameter int BYTE_SEL_W = (DATA_W >= 18) ? DATA_W / `DSPI_BYTE_W : 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_clk,
    input wire logic in_clk_n,
    input wire logic out_clk,
    input wire logic out_clk_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic read_port_sel_n,
    input wire logic write_port_sel_n,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [1:0] nibble_write_sel_n,
    input wire logic [BYTE_SEL_W-1:0] byte_write_sel_n,
    output logic [DATA_W-1:0] q,
    output logic q_oe,
    output logic echo_clk,
    output logic echo_clk_n,
    output logic single_clock_mode,
    output logic read_overrun
);
    // ------------------------------------------------------------
    // Pin capture
    // ------------------------------------------------------------
    // Every pin, clocks included, crosses into clk through the same filtered
    // synchroniser, so data and select bits stay aligned with the clock edges.
    localparam int SEL_W = 2 + BYTE_SEL_W;
    localparam int SYNC_W = 6 + ADDR_W + SEL_W + DATA_W;
    localparam int P_DATA = 0;
    localparam int P_SEL = P_DATA + DATA_W;
    localparam int P_ADDR = P_SEL + SEL_W;
    localparam int P_WPS = P_ADDR + ADDR_W;
    localparam int P_RPS = P_WPS + 1;
    localparam int P_CN = P_RPS + 1;
    localparam int P_C = P_CN + 1;
    localparam int P_KN = P_C + 1;
    localparam int P_K = P_KN + 1;
    localparam int DEPTH_W = ADDR_W;

    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] pin_level;
    logic [SYNC_W-1:0] pin_rise;

    assign pins = {in_clk, in_clk_n, out_clk, out_clk_n, read_port_sel_n,
        write_port_sel_n, addr, byte_write_sel_n, nibble_write_sel_n, wdata};

    dspi_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pin_in(pins),
        .level(pin_level),
        .rise(pin_rise)
    );

    // ------------------------------------------------------------
    // Settling after reset
    // ------------------------------------------------------------
    // The synchroniser wakes with every level at zero, so pins that idle
    // high (K#, C#, the port selects) would show a false rise; edges are
    // ignored until the filter has caught up with the pins.
    logic [2:0] settle_cnt;
    logic settled;

    assign settled = (settle_cnt == `DSPI_SETTLE_CYCLES);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settle_cnt <= 3'h0;
        end else if (!settled) begin
            settle_cnt <= settle_cnt + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Captured pin fields
    // ------------------------------------------------------------
    logic k_rise;
    logic kn_rise;
    logic c_rise;
    logic cn_rise;
    logic rd_sel_n;
    logic wr_sel_n;
    logic [ADDR_W-1:0] cap_addr;
    logic [DATA_W-1:0] cap_data;
    logic [1:0] cap_nib_n;
    logic [BYTE_SEL_W-1:0] cap_byte_n;

    assign k_rise = pin_rise[P_K] & settled;
    assign kn_rise = pin_rise[P_KN] & settled;
    assign c_rise = pin_rise[P_C] & settled;
    assign cn_rise = pin_rise[P_CN] & settled;
    assign rd_sel_n = pin_level[P_RPS];
    assign wr_sel_n = pin_level[P_WPS];
    assign cap_addr = pin_level[P_ADDR +: ADDR_W];
    assign cap_data = pin_level[P_DATA +: DATA_W];
    assign cap_nib_n = pin_level[P_SEL +: 2];
    assign cap_byte_n = pin_level[P_SEL + 2 +: BYTE_SEL_W];

    // ------------------------------------------------------------
    // Write lane mask
    // ------------------------------------------------------------
    // The 8-bit variant uses nibble lanes, all others 9-bit byte lanes;
    // the selects in force are those captured on the same edge as the word.
    function automatic logic lane_on(input int bit_i, input logic [1:0] nib_n,
            input logic [BYTE_SEL_W-1:0] byt_n);
        if (DATA_W == `DSPI_NIBBLE_DATA_W) begin
            lane_on = ~nib_n[bit_i / `DSPI_NIBBLE_W];
        end else begin
            lane_on = ~byt_n[bit_i / `DSPI_BYTE_W];
        end
    endfunction

    logic [DATA_W-1:0] cap_mask;

    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_mask
            assign cap_mask[gi] = lane_on(gi, cap_nib_n, cap_byte_n);
        end
    endgenerate

    // ------------------------------------------------------------
    // Single clock mode detection
    // ------------------------------------------------------------
    // With the output clocks tied inactive no rise ever arrives on them; a
    // few input clock periods without one switch output timing to K.
    logic [2:0] scm_cnt;
    logic [2:0] next_scm_cnt;
    logic next_scm;

    assign next_scm_cnt = (c_rise | cn_rise) ? 3'h0 :
        (k_rise && scm_cnt != `DSPI_SCM_EDGES) ? scm_cnt + 3'h1 : scm_cnt;
    assign next_scm = (next_scm_cnt == `DSPI_SCM_EDGES);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scm_cnt <= 3'h0;
            single_clock_mode <= 1'b0;
        end else begin
            scm_cnt <= next_scm_cnt;
            single_clock_mode <= next_scm;
        end
    end

    // Output timing edges, from C pair or, in single clock mode, K pair
    logic out_rise_true;
    logic out_rise_comp;
    logic out_rise_any;

    assign out_rise_true = single_clock_mode ? k_rise : c_rise;
    assign out_rise_comp = single_clock_mode ? kn_rise : cn_rise;
    assign out_rise_any = out_rise_true | out_rise_comp;

    // ------------------------------------------------------------
    // Memory arrays
    // ------------------------------------------------------------
    // Two half-depth arrays: array zero holds the first word of each burst,
    // array one the second, so one address names a word pair.
    logic [DATA_W-1:0] arr0 [2**DEPTH_W];
    logic [DATA_W-1:0] arr1 [2**DEPTH_W];

    // ------------------------------------------------------------
    // Write port
    // ------------------------------------------------------------
    dspi_wr_state_t wr_state;
    dspi_wr_state_t next_wr_state;
    logic [DATA_W-1:0] wr_word0;
    logic [DATA_W-1:0] wr_mask0;
    logic wr_start;
    logic wr_finish;

    // Address is only looked at on the complement edge of an active write
    assign wr_start = k_rise & ~wr_sel_n;
    assign wr_finish = kn_rise & (wr_state == DSPI_WR_SECOND);

    always_comb begin
        next_wr_state = wr_state;
        case (wr_state)
            DSPI_WR_IDLE: begin
                if (wr_start) begin
                    next_wr_state = DSPI_WR_SECOND;
                end
            end
            DSPI_WR_SECOND: begin
                if (wr_finish) begin
                    next_wr_state = DSPI_WR_IDLE;
                end
            end
            default: begin
                next_wr_state = DSPI_WR_IDLE;
            end
        endcase
    end

    // First word and its lane selects are held until the complement edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_state <= DSPI_WR_IDLE;
            wr_word0 <= '0;
            wr_mask0 <= '0;
        end else begin
            wr_state <= next_wr_state;
            if (wr_start && wr_state == DSPI_WR_IDLE) begin
                wr_word0 <= cap_data;
                wr_mask0 <= cap_mask;
            end
        end
    end

    // Lanes with their select deasserted keep the stored bits
    always_ff @(posedge clk) begin
        if (wr_finish) begin
            arr0[cap_addr] <= (arr0[cap_addr] & ~wr_mask0) | (wr_word0 & wr_mask0);
            arr1[cap_addr] <= (arr1[cap_addr] & ~cap_mask) | (cap_data & cap_mask);
        end
    end

    // ------------------------------------------------------------
    // Read port: fetch both words into a two-entry stage
    // ------------------------------------------------------------
    // The stage feeds the buffer one word per cycle; a read that arrives
    // while the stage is still blocked by a full buffer cannot be held and is
    // dropped, which read_overrun records until reset.
    logic rd_start;
    logic [DATA_W-1:0] stage0;
    logic [DATA_W-1:0] stage1;
    logic [1:0] stage_cnt;
    logic fifo_in_ready;
    logic stage_push;
    logic rd_accept;

    assign rd_start = k_rise & ~rd_sel_n;
    assign stage_push = (stage_cnt != 2'h0) & fifo_in_ready;
    assign rd_accept = rd_start & (stage_cnt == 2'h0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage0 <= '0;
            stage1 <= '0;
            stage_cnt <= 2'h0;
            read_overrun <= 1'b0;
        end else begin
            if (rd_accept) begin
                stage0 <= arr0[cap_addr];
                stage1 <= arr1[cap_addr];
                stage_cnt <= `DSPI_BURST_LEN;
            end else if (stage_push) begin
                stage0 <= stage1;
                stage_cnt <= stage_cnt - 2'h1;
            end
            if (rd_start && !rd_accept) begin
                read_overrun <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data buffer
    // ------------------------------------------------------------
    logic fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;

    dspi_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(stage_cnt != 2'h0),
        .in_ready(fifo_in_ready),
        .in_data(stage0),
        .out_valid(fifo_out_valid),
        .out_ready(out_rise_any),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------
    // One word leaves on each output clock rise; once the buffer is empty
    // the drivers switch off on the next true output clock rise, so the
    // second word of a burst is never cut short.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q_oe <= 1'b0;
        end else if (out_rise_any) begin
            if (fifo_out_valid) begin
                q <= fifo_out_data;
                q_oe <= 1'b1;
            end else if (out_rise_true) begin
                q_oe <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Echo clocks
    // ------------------------------------------------------------
    // Free running copies of the output clock pair (input pair in single
    // clock mode); they lag the pins by the synchroniser delay.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            echo_clk <= 1'b0;
            echo_clk_n <= 1'b0;
        end else begin
            echo_clk <= single_clock_mode ? pin_level[P_K] : pin_level[P_C];
            echo_clk_n <= single_clock_mode ? pin_level[P_KN] : pin_level[P_CN];
        end
    end
endmodule

// [rtl/dspi_cfg.svh]
// Constants of the burst SRAM port interface: widths, lane sizes, timing counts
`ifndef DSPI_CFG_SVH
`define DSPI_CFG_SVH

// ------------------------------------------------------------
// Data and address widths of the widest variant
// ------------------------------------------------------------
`define DSPI_DATA_W 36
`define DSPI_ADDR_W 18
// Address widths of the other variants
`define DSPI_ADDR_W_X8 20
`define DSPI_ADDR_W_X18 19

// ------------------------------------------------------------
// Write lane sizes
// ------------------------------------------------------------
`define DSPI_NIBBLE_W 4
`define DSPI_BYTE_W 9
`define DSPI_NIBBLE_DATA_W 8

// ------------------------------------------------------------
// Read path buffer and mode detection
// ------------------------------------------------------------
`define DSPI_FIFO_DEPTH 8
`define DSPI_SCM_EDGES 3'h4
`define DSPI_BURST_LEN 2'h2
// Clocks after reset before any pin edge is believed
`define DSPI_SETTLE_CYCLES 3'h5

`endif

// [rtl/dspi_pkg.sv]
// Types shared by the burst SRAM port interface
package dspi_pkg;
    // Write burst progress: first word taken, waiting for the second edge
    typedef enum logic [0:0] {
        DSPI_WR_IDLE,
        DSPI_WR_SECOND
    } dspi_wr_state_t;
endpackage

// [rtl/dspi_sync.sv]
// Three-stage pin synchroniser with agreement filter and rising-edge detect
`timescale 1ns/1ps
module dspi_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_level;

    // ------------------------------------------------------------
    // Filter: a change counts only once stages two and three agree
    // ------------------------------------------------------------
    assign next_level = ((s2 ~^ s3) & s3) | (~(s2 ~^ s3) & level);
    assign rise = next_level & ~level;

    // Stage one is read only by stage two, to keep metastability contained
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            level <= '0;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
        end
    end
endmodule

// [rtl/dspi_fifo.sv]
// Read data buffer with valid/ready on both sides
`timescale 1ns/1ps
module dspi_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // Handshake decode
    // ------------------------------------------------------------
    assign in_ready = (count < (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr];

    // Storage is written without reset; only pointers and count need a known value
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap at DEPTH, which may be any value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// [verification/dspi_ctrl_model.sv]
// Behavioural memory controller that drives the pins of the burst SRAM port interface
`timescale 1ns/1ps
module dspi_ctrl_model #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 6,
    parameter int SEL_W = 4
) (
    input wire logic clk,
    input wire logic c_hold,
    output logic in_clk,
    output logic in_clk_n,
    output logic out_clk,
    output logic out_clk_n,
    output logic [ADDR_W-1:0] addr,
    output logic read_port_sel_n,
    output logic write_port_sel_n,
    output logic [DATA_W-1:0] wdata,
    output logic [SEL_W-1:0] byte_write_sel_n
);
    // Idle pins: true clocks low, complement clocks high, ports deselected
    initial begin
        in_clk = 1'b0;
        in_clk_n = 1'b1;
        out_clk = 1'b0;
        out_clk_n = 1'b1;
        addr = '0;
        read_port_sel_n = 1'b1;
        write_port_sel_n = 1'b1;
        wdata = '0;
        byte_write_sel_n = '1;
    end

    // One input clock period of eleven system clocks; every line is set two clocks before
    // the edge that takes it and held until the synchroniser has passed that edge on
    task automatic kcycle(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr,
        input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1,
        input logic [SEL_W-1:0] m0, input logic [SEL_W-1:0] m1);
        @(posedge clk);
        read_port_sel_n <= !rd;
        write_port_sel_n <= !wr;
        // Unused lines flip so a stale value can never pass for a real one
        addr <= rd ? ra : ~addr;
        wdata <= wr ? d0 : ~wdata;
        byte_write_sel_n <= wr ? m0 : ~byte_write_sel_n;
        repeat (2) @(posedge clk);
        in_clk <= 1'b1;
        in_clk_n <= 1'b0;
        out_clk <= !c_hold;
        out_clk_n <= 1'b0;
        repeat (3) @(posedge clk);
        addr <= wr ? wa : ~addr;
        wdata <= wr ? d1 : ~wdata;
        byte_write_sel_n <= wr ? m1 : ~byte_write_sel_n;
        repeat (2) @(posedge clk);
        in_clk <= 1'b0;
        in_clk_n <= 1'b1;
        out_clk <= 1'b0;
        out_clk_n <= !c_hold;
        repeat (3) @(posedge clk);
    endtask
endmodule

// [verification/dspi_top_sva.sv]
// Concurrent checks on the ports of the burst SRAM port interface
`timescale 1ns/1ps
module dspi_top_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_clk,
    input wire logic out_clk,
    input wire logic out_clk_n,
    input wire logic read_port_sel_n,
    input wire logic q_oe,
    input wire logic echo_clk,
    input wire logic echo_clk_n,
    input wire logic single_clock_mode
);
    // ----------------------------------------
    // Age counters
    // ----------------------------------------
    logic [7:0] rd_age;
    logic [7:0] oc_age;
    // Saturating, so a long idle stretch never wraps back into range
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_age <= 8'hFF;
            oc_age <= 8'h00;
        end else begin
            rd_age <= !read_port_sel_n ? 8'h00 : rd_age + {7'h00, rd_age != 8'hFF};
            oc_age <= (out_clk || out_clk_n) ? 8'h00 : oc_age + {7'h00, oc_age != 8'hFF};
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    reset_quiet_a: assert property ($fell(rst) |-> !q_oe && !single_clock_mode)
        else $error("outputs active right after reset");
    oe_needs_read_a: assert property ($rose(q_oe) |-> rd_age < 8'h28)
        else $error("read port drives without a read");
    oe_idle_off_a: assert property (q_oe |-> rd_age < 8'h3C)
        else $error("read port still drives long after last read");
    oe_burst_a: assert property ($rose(q_oe) |-> q_oe [*3])
        else $error("read burst cut short");
    scm_set_a: assert property ($rose(single_clock_mode) |-> oc_age >= 8'h14)
        else $error("single clock mode while output clocks run");
    scm_clear_a: assert property ($rose(out_clk) |-> ##[1:8] !single_clock_mode)
        else $error("single clock mode kept with output clock running");
    echo_true_a: assert property (
        $rose(out_clk) && !single_clock_mode |-> ##[1:6] echo_clk)
        else $error("echo clock does not follow output clock");
    echo_comp_a: assert property (
        $rose(out_clk_n) && !single_clock_mode |-> ##[1:6] echo_clk_n)
        else $error("complement echo does not follow");
    echo_single_a: assert property (
        $rose(in_clk) && single_clock_mode |-> ##[1:6] echo_clk)
        else $error("echo clock does not follow input clock");
endmodule

// [verification/dspi_top_bench.sv]
// Self-checking bench of the burst SRAM port interface
`timescale 1ns/1ps
module dspi_top_bench;
    localparam int DW = 36;
    localparam int AW = 6;
    logic clk, rst, hold_c, in_clk, in_clk_n, out_clk, out_clk_n, rps_n, wps_n;
    logic q_oe, echo_clk, echo_clk_n, scm, overrun, prev_oe;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, q, prev_q;
    logic [3:0] bws_n;
    logic [DW-1:0] got[$];
    int failures;
    int samples_checked;

    // ----------------------------------------
    // Clock, model and design
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    dspi_ctrl_model #(.DATA_W(DW), .ADDR_W(AW), .SEL_W(4)) u_ctrl (.clk(clk), .c_hold(hold_c),
        .in_clk(in_clk), .in_clk_n(in_clk_n), .out_clk(out_clk), .out_clk_n(out_clk_n),
        .addr(addr), .read_port_sel_n(rps_n), .write_port_sel_n(wps_n), .wdata(wdata),
        .byte_write_sel_n(bws_n));
    // Nibble selects only matter in the 8-bit variant
    dspi_top #(.DATA_W(DW), .ADDR_W(AW), .FIFO_DEPTH(8)) dut (.clk(clk), .rst(rst),
        .in_clk(in_clk), .in_clk_n(in_clk_n), .out_clk(out_clk), .out_clk_n(out_clk_n),
        .addr(addr), .read_port_sel_n(rps_n), .write_port_sel_n(wps_n), .wdata(wdata),
        .nibble_write_sel_n(2'h3), .byte_write_sel_n(bws_n), .q(q), .q_oe(q_oe),
        .echo_clk(echo_clk), .echo_clk_n(echo_clk_n), .single_clock_mode(scm),
        .read_overrun(overrun));

    // Record each new word while the read port drives; test words differ, so changes count
    always @(posedge clk) begin
        if (q_oe === 1'b1 && (prev_oe !== 1'b1 || q !== prev_q)) begin
            got.push_back(q);
        end
        prev_q <= q;
        prev_oe <= q_oe;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) u_ctrl.kcycle(1'b0, '0, 1'b0, '0, '0, '0, 4'hF, 4'hF);
    endtask
    task automatic write(input logic [AW-1:0] a, input logic [DW-1:0] d0, input logic [DW-1:0] d1,
        input logic [3:0] m0, input logic [3:0] m1);
        u_ctrl.kcycle(1'b0, '0, 1'b1, a, d0, d1, m0, m1);
    endtask
    // Check the two words of the last burst and that the port let go afterwards
    task automatic burst_check(input logic [DW-1:0] e0, input logic [DW-1:0] e1);
        idle(4);
        check("burst length", DW'(got.size()), DW'(2));
        check("first word", got[0], e0);
        check("second word", got[1], e1);
        check("drive after burst", DW'(q_oe), '0);
    endtask
    task automatic read_expect(input logic [AW-1:0] a, input logic [DW-1:0] e0,
        input logic [DW-1:0] e1);
        got.delete();
        u_ctrl.kcycle(1'b1, a, 1'b0, '0, '0, '0, 4'hF, 4'hF);
        burst_check(e0, e1);
    endtask
    // Lanes whose select is high keep the old 9-bit lane
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
        input logic [DW-1:0] new_w, input logic [3:0] m);
        logic [DW-1:0] r;
        r = new_w;
        for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
                r[i*9 +: 9] = old_w[i*9 +: 9];
            end
        end
        return r;
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        check("drive after reset", DW'(q_oe), '0);
        check("mode after reset", DW'(scm), '0);
        $display("test reset done");
    endtask
    // Read and write in one period use the read address first, the write address second
    task automatic t_basic;
        write(6'h05, 36'hA5A5A5A5A, 36'h5A5A5A5A5, 4'h0, 4'h0);
        read_expect(6'h05, 36'hA5A5A5A5A, 36'h5A5A5A5A5);
        got.delete();
        u_ctrl.kcycle(1'b1, 6'h05, 1'b1, 6'h2A, 36'h123456789, 36'h9ABCDEF01, 4'h0, 4'h0);
        burst_check(36'hA5A5A5A5A, 36'h5A5A5A5A5);
        read_expect(6'h2A, 36'h123456789, 36'h9ABCDEF01);
        $display("test basic done");
    endtask
    // Each lane gated both ways, independently on each word, at the top address
    task automatic t_lanes;
        write(6'h3F, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
        write(6'h3F, 36'hFFFFFFFFF, 36'hEEEEEEEEE, 4'hA, 4'h5);
        read_expect(6'h3F, merge(36'h111111111, 36'hFFFFFFFFF, 4'hA),
            merge(36'h222222222, 36'hEEEEEEEEE, 4'h5));
        $display("test lanes done");
    endtask
    // Deselected write port with live data and address must leave memory alone
    task automatic t_desel;
        u_ctrl.kcycle(1'b0, 6'h05, 1'b0, 6'h05, '0, '0, 4'h0, 4'h0);
        read_expect(6'h05, 36'hA5A5A5A5A, 36'h5A5A5A5A5);
        $display("test deselect done");
    endtask
    // Output clocks held still: input clocks time the read data instead
    task automatic t_single;
        int n;
        hold_c <= 1'b1;
        n = 0;
        while (scm !== 1'b1 && n < 10) begin
            idle(1);
            n++;
        end
        if (n == 10) begin
            failures++;
            print_verdict;
        end
        check("single mode on", DW'(scm), DW'(1));
        read_expect(6'h2A, 36'h123456789, 36'h9ABCDEF01);
        hold_c <= 1'b0;
        idle(2);
        check("single mode off", DW'(scm), '0);
        check("no dropped read", DW'(overrun), '0);
        $display("test single clock done");
    endtask

    initial begin
        rst = 1'b1;
        hold_c = 1'b0;
        failures = 0;
        samples_checked = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_basic;
        t_lanes;
        t_desel;
        t_single;
        print_verdict;
    end
    // Cut a hang short
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        print_verdict;
    end
endmodule

bind dspi_top dspi_top_sva u_sva (.clk(clk), .rst(rst), .in_clk(in_clk), .out_clk(out_clk),
    .out_clk_n(out_clk_n), .read_port_sel_n(read_port_sel_n), .q_oe(q_oe),
    .echo_clk(echo_clk), .echo_clk_n(echo_clk_n), .single_clock_mode(single_clock_mode));
